/* File: logic/zf_cmd_pkg.sv */
// Overview of operation
// - four-bit switchhook debounce time in milliseconds
// - line-detect bit changes after stable debounce time
// - strobe pulses low, only in clock mode
// - chopper enable bit gates chopper clock output
// - configuration register resets to 20h
// - configuration applies to all four channels
// - read sample returns sample then reserved byte
// - sample byte companded, or linear upper byte
// - fir commands move ten bytes, z0 to z4
// - iir commands move five bytes, z5 to z7
// - 32 kHz filter, five taps plus iir
// - four signed-shift terms, z6 only two
// - every coefficient word resets to 0190h, the z6 byte to 90h
// - iir output scaled by z6, input by z5 (any 1/z6 folded into z5)
// - nibble is sign bit plus 3-bit shift
package zf_cmd_pkg;
   localparam int CLK_HZ = 10_000_000;
   localparam int DEBOUNCE_UNIT_US = 1000;
   localparam int MS_CYCLES = CLK_HZ / 1_000_000 * DEBOUNCE_UNIT_US;
   localparam int ZF_RATE_HZ = 32_000;
   localparam int ZF_TICK_CYCLES = CLK_HZ / ZF_RATE_HZ;
   localparam int CHOP_HZ = 250_000;
   localparam int CHOP_HALF_CYCLES = CLK_HZ / (2 * CHOP_HZ);
   localparam int NUM_CHANNELS = 4;
   localparam int FIR_TAPS = 5;
   localparam int ACC_W = 28;
   localparam int FRAC_BITS = 8;

   localparam logic [7:0] CMD_CFG_WR = 8'hc8;
   localparam logic [7:0] CMD_CFG_RD = 8'hc9;
   localparam logic [7:0] CMD_TX_RD = 8'hcd;
   localparam logic [7:0] CMD_ZFIR_WR = 8'h98;
   localparam logic [7:0] CMD_ZFIR_RD = 8'h99;
   localparam logic [7:0] CMD_ZIIR_WR = 8'h9a;
   localparam logic [7:0] CMD_ZIIR_RD = 8'h9b;
   localparam int RW_BIT = 0;

   localparam logic [6:0] CFG_BITS = 7'h08;
   localparam logic [6:0] TX_BITS = 7'h10;
   localparam logic [6:0] ZFIR_BITS = 7'h50;
   localparam logic [6:0] ZIIR_BITS = 7'h28;

   localparam logic [7:0] CFG_RESET = 8'h20;
   localparam logic [15:0] ZCOEF_RESET = 16'h0190;
   localparam logic [7:0] Z6_RESET = 8'h90;
   localparam logic [7:0] RESERVED_BITS_BYTE = 8'h00;

   typedef struct packed {
      logic strobe_output_enable;
      logic strobe_output_polarity;
      logic [3:0] switchhook_debounce_ms;
      logic reserved_bits;
      logic chopper_enable;
   } cfg_t;

   typedef logic [FIR_TAPS-1:0][15:0] zfir_t;

   typedef struct packed {
      logic [15:0] z5;
      logic [7:0] z6;
      logic [15:0] z7;
   } ziir_t;

   typedef struct packed {
      logic clock_mode_select;
      logic cs_n;
      logic dclk;
      logic din;
      logic [NUM_CHANNELS-1:0] line;
   } pins_t;

   typedef enum logic [2:0] {
      ST_CMD = 3'b001,
      ST_WR = 3'b010,
      ST_RD = 3'b100
   } port_state_t;
endpackage : zf_cmd_pkg

/* File: logic/zf_csd_mult.sv */
`timescale 1ns/1ps
module zf_csd_mult #(
   parameter int TERMS = 4
) (
   input wire logic signed [27:0] i_sample,
   input wire logic [15:0] i_coef,
   output logic signed [27:0] o_product
);
   // nested form, innermost term first: s1 2^-m1 x(1 + s2 2^-m2 (1 + s3 2^-m3 (1 + s4 2^-m4)))
   always_comb begin
      logic signed [27:0] acc;
      logic signed [27:0] sh;
      acc = i_sample;
      sh = '0;
      for (int k = TERMS - 1; k >= 1; k--) begin
         sh = acc >>> i_coef[4*k +: 3];
         acc = i_coef[4*k+3] ? i_sample - sh : i_sample + sh;
      end
      sh = acc >>> i_coef[2:0];
      o_product = i_coef[3] ? -sh : sh;
   end
endmodule : zf_csd_mult

/* File: logic/host_cmd_debounce_zfilter.sv */
`timescale 1ns/1ps
module host_cmd_debounce_zfilter
   import zf_cmd_pkg::*;
#(
   parameter int MS_CYCLES_P = zf_cmd_pkg::MS_CYCLES
) (
   input wire logic i_ref_clk,
   input wire logic i_rst_n,
   input wire logic i_host_dclk,
   input wire logic i_host_cs_n,
   input wire logic i_host_din,
   output logic o_host_dout,
   output logic o_host_dout_oe,
   input wire logic i_clock_mode_select,
   input wire logic [zf_cmd_pkg::NUM_CHANNELS-1:0] i_first_line_detect_input,
   output logic [zf_cmd_pkg::NUM_CHANNELS-1:0] o_rt_line_detect,
   output logic o_auxiliary_strobe_output_n,
   output logic o_chopper_clock_output,
   input wire logic i_linear_mode,
   input wire logic [7:0] i_tx_companded,
   input wire logic [15:0] i_tx_linear,
   input wire logic [15:0] i_zf_in,
   output logic [15:0] o_zf_out
);
   import zf_cmd_pkg::*;

   // pin synchronisers; the first stage feeds only the second
   pins_t meta_ff;
   pins_t sync_ff;
   logic dclk_prev_ff;
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         meta_ff <= '{cs_n: 1'b1, default: '0};
         sync_ff <= '{cs_n: 1'b1, default: '0};
         dclk_prev_ff <= 1'b0;
      end else begin
         meta_ff <= '{clock_mode_select: i_clock_mode_select, cs_n: i_host_cs_n,
                      dclk: i_host_dclk, din: i_host_din, line: i_first_line_detect_input};
         sync_ff <= meta_ff;
         dclk_prev_ff <= sync_ff.dclk;
      end
   end
   logic dclk_rise;
   assign dclk_rise = sync_ff.dclk & ~dclk_prev_ff;

   // ---------------- command port ----------------
   port_state_t state_ff, nxt_state;
   logic [6:0] bit_cnt_ff, nxt_bit_cnt;
   logic [6:0] len_ff, nxt_len;
   logic [7:0] cmd_ff, nxt_cmd;
   logic [79:0] shin_ff, nxt_shin;
   logic [79:0] rd_img_ff, nxt_rd_img;
   logic dout_ff, nxt_dout;
   logic oe_ff, nxt_oe;
   logic wr_commit;

   cfg_t cfg_ff, nxt_cfg;
   zfir_t zfir_ff, nxt_zfir;
   ziir_t ziir_ff, nxt_ziir;

   logic [7:0] tx_byte;
   assign tx_byte = i_linear_mode ? i_tx_linear[15:8] : i_tx_companded;

   always_comb begin
      logic [7:0] cmd_byte;
      logic [79:0] img;
      nxt_state = state_ff;
      nxt_bit_cnt = bit_cnt_ff;
      nxt_len = len_ff;
      nxt_cmd = cmd_ff;
      nxt_shin = shin_ff;
      nxt_rd_img = rd_img_ff;
      nxt_dout = dout_ff;
      nxt_oe = oe_ff;
      wr_commit = 1'b0;
      cmd_byte = {shin_ff[6:0], sync_ff.din};
      img = '0;
      if (sync_ff.cs_n) begin
         // deselect aborts any transfer; a partial write never lands
         nxt_state = ST_CMD;
         nxt_bit_cnt = '0;
         nxt_oe = 1'b0;
      end else if (dclk_rise) begin
         nxt_shin = {shin_ff[78:0], sync_ff.din};
         nxt_bit_cnt = bit_cnt_ff + 7'h01;
         case (state_ff)
            ST_CMD: begin
               if (bit_cnt_ff == 7'h07) begin
                  nxt_bit_cnt = '0;
                  nxt_cmd = cmd_byte;
                  case (cmd_byte)
                     CMD_CFG_WR: begin
                        nxt_state = ST_WR;
                        nxt_len = CFG_BITS;
                     end
                     CMD_ZFIR_WR: begin
                        nxt_state = ST_WR;
                        nxt_len = ZFIR_BITS;
                     end
                     CMD_ZIIR_WR: begin
                        nxt_state = ST_WR;
                        nxt_len = ZIIR_BITS;
                     end
                     CMD_CFG_RD: begin
                        nxt_state = ST_RD;
                        nxt_len = CFG_BITS;
                        img = {cfg_ff, 72'h0};
                     end
                     CMD_TX_RD: begin
                        nxt_state = ST_RD;
                        nxt_len = TX_BITS;
                        img = {tx_byte, RESERVED_BITS_BYTE, 64'h0};
                     end
                     CMD_ZFIR_RD: begin
                        nxt_state = ST_RD;
                        nxt_len = ZFIR_BITS;
                        img = zfir_ff;
                     end
                     CMD_ZIIR_RD: begin
                        nxt_state = ST_RD;
                        nxt_len = ZIIR_BITS;
                        img = {ziir_ff, 40'h0};
                     end
                     default: begin
                        nxt_state = ST_CMD;
                     end
                  endcase
                  if (nxt_state == ST_RD) begin
                     nxt_dout = img[79];
                     nxt_rd_img = {img[78:0], 1'b0};
                     nxt_oe = 1'b1;
                  end
               end
            end
            ST_WR: begin
               if (bit_cnt_ff == len_ff - 7'h01) begin
                  wr_commit = 1'b1;
                  nxt_state = ST_CMD;
                  nxt_bit_cnt = '0;
               end
            end
            ST_RD: begin
               // the host samples on the rising edge, so the next bit follows it
               if (bit_cnt_ff == len_ff - 7'h01) begin
                  nxt_state = ST_CMD;
                  nxt_bit_cnt = '0;
                  nxt_oe = 1'b0;
               end else begin
                  nxt_dout = rd_img_ff[79];
                  nxt_rd_img = {rd_img_ff[78:0], 1'b0};
               end
            end
            default: begin
               nxt_state = ST_CMD;
               nxt_bit_cnt = '0;
               nxt_oe = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         state_ff <= ST_CMD;
         bit_cnt_ff <= '0;
         len_ff <= '0;
         cmd_ff <= '0;
         shin_ff <= '0;
         rd_img_ff <= '0;
         dout_ff <= 1'b0;
         oe_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         bit_cnt_ff <= nxt_bit_cnt;
         len_ff <= nxt_len;
         cmd_ff <= nxt_cmd;
         shin_ff <= nxt_shin;
         rd_img_ff <= nxt_rd_img;
         dout_ff <= nxt_dout;
         oe_ff <= nxt_oe;
      end
   end
   assign o_host_dout = dout_ff;
   assign o_host_dout_oe = oe_ff;

   // ---------------- registers ----------------
   always_comb begin
      nxt_cfg = cfg_ff;
      nxt_zfir = zfir_ff;
      nxt_ziir = ziir_ff;
      if (wr_commit) begin
         case (cmd_ff)
            CMD_CFG_WR: nxt_cfg = cfg_t'(nxt_shin[7:0]);
            CMD_ZFIR_WR: nxt_zfir = zfir_t'(nxt_shin);
            CMD_ZIIR_WR: nxt_ziir = ziir_t'(nxt_shin[39:0]);
            default: nxt_cfg = cfg_ff;
         endcase
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         cfg_ff <= cfg_t'(CFG_RESET);
         zfir_ff <= {FIR_TAPS{ZCOEF_RESET}};
         ziir_ff <= '{z5: ZCOEF_RESET, z6: Z6_RESET, z7: ZCOEF_RESET};
      end else begin
         cfg_ff <= nxt_cfg;
         zfir_ff <= nxt_zfir;
         ziir_ff <= nxt_ziir;
      end
   end

   // ---------------- debounce ----------------
   logic [15:0] ms_cnt_ff, nxt_ms_cnt;
   logic ms_tick;
   assign ms_tick = (ms_cnt_ff == 16'(MS_CYCLES_P - 1));
   always_comb nxt_ms_cnt = ms_tick ? 16'h0000 : ms_cnt_ff + 16'h0001;
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) ms_cnt_ff <= '0;
      else ms_cnt_ff <= nxt_ms_cnt;
   end

   // one shared debounce time for every channel
   logic [NUM_CHANNELS-1:0] rt_ff, nxt_rt;
   logic [NUM_CHANNELS-1:0][3:0] db_cnt_ff, nxt_db_cnt;
   for (genvar ch = 0; ch < NUM_CHANNELS; ch++) begin : g_debounce
      always_comb begin
         nxt_rt[ch] = rt_ff[ch];
         nxt_db_cnt[ch] = db_cnt_ff[ch];
         if (sync_ff.line[ch] == rt_ff[ch]) begin
            nxt_db_cnt[ch] = '0;
         end else if (cfg_ff.switchhook_debounce_ms == 4'h0) begin
            nxt_rt[ch] = sync_ff.line[ch];
         end else if (ms_tick) begin
            // the first millisecond may be partial, so the window is short by under 1 ms
            if (db_cnt_ff[ch] + 4'h1 >= cfg_ff.switchhook_debounce_ms) begin
               nxt_rt[ch] = sync_ff.line[ch];
               nxt_db_cnt[ch] = '0;
            end else begin
               nxt_db_cnt[ch] = db_cnt_ff[ch] + 4'h1;
            end
         end
      end
   end
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         rt_ff <= '0;
         db_cnt_ff <= '0;
      end else begin
         rt_ff <= nxt_rt;
         db_cnt_ff <= nxt_db_cnt;
      end
   end
   assign o_rt_line_detect = rt_ff;

   // ---------------- impedance filter ----------------
   logic [8:0] zf_cnt_ff, nxt_zf_cnt;
   logic zf_tick;
   logic [FIR_TAPS-2:0][15:0] hist_ff, nxt_hist;
   logic signed [ACC_W-1:0] v_ff, nxt_v;
   logic [15:0] zout_ff, nxt_zout;
   logic signed [FIR_TAPS-1:0][ACC_W-1:0] tap;
   logic signed [FIR_TAPS-1:0][ACC_W-1:0] fir_prod;
   logic signed [ACC_W-1:0] iir_in, v_new, iir_out;

   assign zf_tick = (zf_cnt_ff == 9'(ZF_TICK_CYCLES - 1));
   assign tap[0] = ACC_W'({{4{i_zf_in[15]}}, i_zf_in, 8'h00});

   for (genvar t = 0; t < FIR_TAPS; t++) begin : g_fir
      if (t > 0) begin : g_tap
         assign tap[t] = ACC_W'({{4{hist_ff[t-1][15]}}, hist_ff[t-1], 8'h00});
      end
      zf_csd_mult #(.TERMS(4)) u_fir (
         .i_sample(tap[t]),
         .i_coef(zfir_ff[FIR_TAPS-1-t]),
         .o_product(fir_prod[t])
      );
   end

   // the 1/z6 input gain lives in the programmed z5, so only z6 is applied here
   zf_csd_mult #(.TERMS(4)) u_z5 (
      .i_sample(tap[1]),
      .i_coef(ziir_ff.z5),
      .o_product(iir_in)
   );
   zf_csd_mult #(.TERMS(4)) u_z7 (
      .i_sample(v_ff + iir_in),
      .i_coef(ziir_ff.z7),
      .o_product(v_new)
   );
   zf_csd_mult #(.TERMS(2)) u_z6 (
      .i_sample(v_new),
      .i_coef({8'h00, ziir_ff.z6}),
      .o_product(iir_out)
   );

   always_comb begin
      logic signed [ACC_W-1:0] sum;
      sum = iir_out;
      for (int t = 0; t < FIR_TAPS; t++) begin
         sum = sum + fir_prod[t];
      end
      nxt_zf_cnt = zf_tick ? 9'h000 : zf_cnt_ff + 9'h001;
      nxt_hist = hist_ff;
      nxt_v = v_ff;
      nxt_zout = zout_ff;
      if (zf_tick) begin
         nxt_hist = {hist_ff[FIR_TAPS-3:0], i_zf_in};
         nxt_v = v_new;
         // saturate rather than wrap: a wrapped sample would click loudly
         if (sum[ACC_W-1:FRAC_BITS+15] != {(ACC_W-FRAC_BITS-15){sum[ACC_W-1]}}) begin
            nxt_zout = sum[ACC_W-1] ? 16'h8000 : 16'h7fff;
         end else begin
            nxt_zout = sum[FRAC_BITS +: 16];
         end
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         zf_cnt_ff <= '0;
         hist_ff <= '0;
         v_ff <= '0;
         zout_ff <= '0;
      end else begin
         zf_cnt_ff <= nxt_zf_cnt;
         hist_ff <= nxt_hist;
         v_ff <= nxt_v;
         zout_ff <= nxt_zout;
      end
   end
   assign o_zf_out = zout_ff;

   // ---------------- chopper and strobe ----------------
   logic [7:0] chop_cnt_ff, nxt_chop_cnt;
   logic chop_ff, nxt_chop;
   logic strobe_n_ff, nxt_strobe_n;
   always_comb begin
      nxt_chop_cnt = '0;
      nxt_chop = 1'b0;
      if (cfg_ff.chopper_enable) begin
         nxt_chop = chop_ff;
         nxt_chop_cnt = chop_cnt_ff + 8'h01;
         if (chop_cnt_ff == 8'(CHOP_HALF_CYCLES - 1)) begin
            nxt_chop_cnt = '0;
            nxt_chop = ~chop_ff;
         end
      end
      // one-cycle low pulse per filter frame
      nxt_strobe_n = ~(sync_ff.clock_mode_select & cfg_ff.strobe_output_enable & zf_tick);
   end
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         chop_cnt_ff <= '0;
         chop_ff <= 1'b0;
         strobe_n_ff <= 1'b1;
      end else begin
         chop_cnt_ff <= nxt_chop_cnt;
         chop_ff <= nxt_chop;
         strobe_n_ff <= nxt_strobe_n;
      end
   end
   assign o_chopper_clock_output = chop_ff;
   assign o_auxiliary_strobe_output_n = strobe_n_ff;
endmodule : host_cmd_debounce_zfilter

/* File: tb/host_cmd_debounce_zfilter_checker.sv */
`timescale 1ns/1ps
module host_cmd_debounce_zfilter_checker
   import zf_cmd_pkg::*;
#(
   parameter int MS_CYCLES_P = zf_cmd_pkg::MS_CYCLES
) (
   input wire logic i_ref_clk,
   input wire logic i_rst_n,
   input wire logic i_host_dclk,
   input wire logic i_host_cs_n,
   input wire logic i_clock_mode_select,
   input wire logic [zf_cmd_pkg::NUM_CHANNELS-1:0] i_first_line_detect_input,
   input wire logic o_host_dout,
   input wire logic o_host_dout_oe,
   input wire logic [zf_cmd_pkg::NUM_CHANNELS-1:0] o_rt_line_detect,
   input wire logic o_auxiliary_strobe_output_n,
   input wire logic o_chopper_clock_output,
   input wire logic [15:0] o_zf_out
);
   int hi_ff;
   int nxt_hi;
   int gap_ff;
   int nxt_gap;
   logic seen_ff;
   logic nxt_seen;
   default clocking cb @(posedge i_ref_clk);
   endclocking
   default disable iff (!i_rst_n);
   always_comb begin
      nxt_hi = o_chopper_clock_output ? hi_ff + 1 : 0;
      nxt_gap = o_auxiliary_strobe_output_n ? gap_ff + 1 : 0;
      nxt_seen = seen_ff | !o_auxiliary_strobe_output_n;
   end
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         hi_ff <= 0;
         gap_ff <= 0;
         seen_ff <= 1'b0;
      end else begin
         hi_ff <= nxt_hi;
         gap_ff <= nxt_gap;
         seen_ff <= nxt_seen;
      end
   end
   a_reset_quiet: assert property ($rose(i_rst_n) |-> !o_host_dout_oe &&
      o_auxiliary_strobe_output_n && !o_chopper_clock_output && o_zf_out == 16'h0000)
      else $error("outputs not quiet after reset");
   a_strobe_gated: assert property ((!i_clock_mode_select)[*4] |->
      o_auxiliary_strobe_output_n) else $error("strobe outside clock mode");
   a_strobe_single: assert property ($fell(o_auxiliary_strobe_output_n) |=>
      o_auxiliary_strobe_output_n) else $error("strobe longer than one cycle");
   a_strobe_period: assert property (seen_ff && !o_auxiliary_strobe_output_n |->
      (gap_ff % ZF_TICK_CYCLES) == ZF_TICK_CYCLES - 1) else $error("strobe off tick");
   a_chop_halfwave: assert property (hi_ff <= CHOP_HALF_CYCLES)
      else $error("chopper high too long");
   a_cs_abort: assert property (i_host_cs_n[*6] |-> !o_host_dout_oe)
      else $error("dout driven while deselected");
   a_dout_hold: assert property (($stable(i_host_dclk) && $stable(i_host_cs_n))[*5] |->
      $stable(o_host_dout) && $stable(o_host_dout_oe)) else $error("dout moved idle");
   // only the bits that moved are held against their own pin; the others may still be counting
   a_line_follow: assert property ($changed(o_rt_line_detect) |->
      ((o_rt_line_detect ^ $past(o_rt_line_detect)) &
      (o_rt_line_detect ^ $past(i_first_line_detect_input, 2))) == '0)
      else $error("line bit moved against input");
endmodule : host_cmd_debounce_zfilter_checker

bind host_cmd_debounce_zfilter host_cmd_debounce_zfilter_checker #(
   .MS_CYCLES_P(MS_CYCLES_P)
) host_cmd_debounce_zfilter_checker_inst (
   .i_ref_clk(i_ref_clk),
   .i_rst_n(i_rst_n),
   .i_host_dclk(i_host_dclk),
   .i_host_cs_n(i_host_cs_n),
   .i_clock_mode_select(i_clock_mode_select),
   .i_first_line_detect_input(i_first_line_detect_input),
   .o_host_dout(o_host_dout),
   .o_host_dout_oe(o_host_dout_oe),
   .o_rt_line_detect(o_rt_line_detect),
   .o_auxiliary_strobe_output_n(o_auxiliary_strobe_output_n),
   .o_chopper_clock_output(o_chopper_clock_output),
   .o_zf_out(o_zf_out)
);

/* File: tb/host_port_model.sv */
`timescale 1ns/1ps
module host_port_model
   import zf_cmd_pkg::*;
(
   input wire logic i_ref_clk,
   input wire logic i_dout,
   output logic o_dclk,
   output logic o_cs_n,
   output logic o_din
);
   initial begin
      o_dclk = 1'b0;
      o_cs_n = 1'b1;
      o_din = 1'b0;
   end
   task automatic step(input int n);
      repeat (n) @(posedge i_ref_clk);
      #5;
   endtask : step
   // read data is taken just before each rise, when the previous shift has settled
   task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
      for (int i = 7; i >= 0; i--) begin
         o_din = tx[i];
         o_dclk = 1'b0;
         step(5);
         rx[i] = i_dout;
         o_dclk = 1'b1;
         step(5);
      end
   endtask : xfer
   task automatic frame(input logic [7:0] op, input int n, inout logic [7:0] d [16]);
      logic [7:0] tx;
      logic [7:0] rx;
      o_cs_n = 1'b0;
      step(5);
      xfer(op, rx);
      for (int k = 0; k < n; k++) begin
         // din toggles on reads so a stale level cannot pass for data
         tx = op[RW_BIT] ? {4{k[0], ~k[0]}} : d[k];
         if (op == CMD_CFG_WR) tx[1] = 1'b0;
         if (op == CMD_ZIIR_WR && k == 2) tx[3] = 1'b0;
         xfer(tx, rx);
         if (op[RW_BIT]) d[k] = rx;
      end
      o_dclk = 1'b0;
      step(5);
      o_cs_n = 1'b1;
      step(5);
   endtask : frame
endmodule : host_port_model

/* File: tb/host_cmd_debounce_zfilter_tb.sv */
`timescale 1ns/1ps
module host_cmd_debounce_zfilter_tb;
   import zf_cmd_pkg::*;
   logic ref_clk = 1'b0;
   logic rst_n = 1'b0;
   logic dclk, cs_n, din, dout, dout_oe, strobe_n, chop;
   logic clock_mode = 1'b0;
   logic linear = 1'b0;
   logic [3:0] line = 4'h0;
   logic [3:0] rt;
   logic [7:0] tx_comp = 8'h00;
   logic [15:0] tx_lin = 16'h0000;
   logic [15:0] zf_in = 16'h0000;
   logic [15:0] zf_out;
   logic host_line;
   logic [7:0] d [16];
   logic [39:0] iir_rst = {ZCOEF_RESET, Z6_RESET, ZCOEF_RESET};
   // z5 = 1, z6 = 1/4, z7 = 1/2: the iir path has a dc gain of 1/4
   logic [39:0] iir_new = 40'h0111910112;
   logic [15:0] zw [2] = '{16'h0901, 16'h0909};
   logic [15:0] zexp [2] = '{16'h0090, 16'hff70};
   int error_cnt = 0;
   int compares = 0;
   int chg;
   int lows;
   always #50 ref_clk = ~ref_clk;
   host_cmd_debounce_zfilter #(.MS_CYCLES_P(20)) host_cmd_debounce_zfilter_inst (
      .i_ref_clk(ref_clk), .i_rst_n(rst_n), .i_host_dclk(dclk), .i_host_cs_n(cs_n),
      .i_host_din(din), .o_host_dout(dout), .o_host_dout_oe(dout_oe),
      .i_clock_mode_select(clock_mode), .i_first_line_detect_input(line),
      .o_rt_line_detect(rt), .o_auxiliary_strobe_output_n(strobe_n),
      .o_chopper_clock_output(chop), .i_linear_mode(linear), .i_tx_companded(tx_comp),
      .i_tx_linear(tx_lin), .i_zf_in(zf_in), .o_zf_out(zf_out));
   // no pull on the line: a released output shows the inverse, so a late sample fails
   assign host_line = dout_oe ? dout : ~dout;
   host_port_model host_port_model_inst (.i_ref_clk(ref_clk), .i_dout(host_line),
      .o_dclk(dclk), .o_cs_n(cs_n), .o_din(din));
   task automatic wait_clk(input int n);
      repeat (n) @(posedge ref_clk);
      #5;
   endtask : wait_clk
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      compares++;
      if (got !== exp) begin
         error_cnt++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check
   task automatic run(input logic [7:0] op, input int n);
      host_port_model_inst.frame(op, n, d);
   endtask : run
   task automatic watch(input int n);
      logic last;
      last = chop;
      chg = 0;
      lows = 0;
      repeat (n) begin
         wait_clk(1);
         if (chop !== last) chg++;
         if (strobe_n !== 1'b1) lows++;
         last = chop;
      end
   endtask : watch
   task automatic test_done;
      $display("comparisons %0d mismatches %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : test_done
   initial begin
      wait_clk(60000);
      error_cnt++;
      $display("watchdog expired");
      test_done();
   end
   initial begin
      wait_clk(5);
      rst_n = 1'b1;
      wait_clk(3);
      run(CMD_CFG_RD, 1);
      check(16'(d[0]), 16'(CFG_RESET));
      run(CMD_ZIIR_RD, 5);
      for (int k = 0; k < 5; k++) check(16'(d[k]), 16'(iir_rst[39-8*k -: 8]));
      zf_in = 16'h0120;
      wait_clk(3 * ZF_TICK_CYCLES);
      check(zf_out, 16'h0000);
      $display("reset test done");
      d[0] = 8'h81;
      run(CMD_CFG_WR, 1);
      run(CMD_CFG_RD, 1);
      check(16'(d[0]), 16'h0081);
      clock_mode = 1'b1;
      watch(700);
      check(16'(chg >= 30), 16'h0001);
      check(16'(lows >= 2), 16'h0001);
      d[0] = 8'h80;
      run(CMD_CFG_WR, 1);
      clock_mode = 1'b0;
      wait_clk(5);
      watch(700);
      check(16'(chg + lows), 16'h0000);
      $display("chopper strobe test done");
      d[0] = 8'h0c;
      run(CMD_CFG_WR, 1);
      for (int c = 0; c < 4; c++) begin
         line[c] = 1'b1;
         wait_clk(30);
         check(16'(rt[c]), 16'h0000);
         wait_clk(60);
         check(16'(rt[c]), 16'h0001);
      end
      line[0] = 1'b0;
      wait_clk(20);
      check(16'(rt[0]), 16'h0001);
      line[0] = 1'b1;
      wait_clk(100);
      check(16'(rt), 16'h000f);
      $display("debounce test done");
      tx_comp = 8'ha5;
      run(CMD_TX_RD, 2);
      check({d[0], d[1]}, {8'ha5, RESERVED_BITS_BYTE});
      linear = 1'b1;
      tx_lin = 16'h9c3e;
      run(CMD_TX_RD, 2);
      check(16'(d[0]), 16'h009c);
      $display("sample test done");
      for (int t = 0; t < 2; t++) begin
         for (int k = 0; k < 10; k++) d[k] = k[0] ? 8'h90 : 8'h01;
         {d[0], d[1]} = zw[t];
         run(CMD_ZFIR_WR, 10);
         run(CMD_ZFIR_RD, 10);
         check({d[0], d[1]}, zw[t]);
         check({d[8], d[9]}, ZCOEF_RESET);
         wait_clk(3 * ZF_TICK_CYCLES);
         check(zf_out, zexp[t]);
      end
      run(CMD_ZIIR_RD, 5);
      for (int k = 0; k < 5; k++) check(16'(d[k]), 16'(iir_rst[39-8*k -: 8]));
      for (int k = 0; k < 5; k++) d[k] = iir_new[39-8*k -: 8];
      run(CMD_ZIIR_WR, 5);
      run(CMD_ZIIR_RD, 5);
      for (int k = 0; k < 5; k++) check(16'(d[k]), 16'(iir_new[39-8*k -: 8]));
      run(CMD_ZFIR_RD, 10);
      check({d[0], d[1]}, zw[1]);
      wait_clk(20 * ZF_TICK_CYCLES);
      check(zf_out, 16'hffb8);
      $display("filter test done");
      test_done();
   end
endmodule : host_cmd_debounce_zfilter_tb
